// File: rde_params.svh
// Purpose: constants for the register decrement execute block
// Assumes: 16-bit instruction word, 8-bit data memory, 12-bit data address
// Notes:   access bank split and index limit are plain defaults
`ifndef RDE_PARAMS_SVH
`define RDE_PARAMS_SVH
`define RDE_OPC_DECR        6'h01
`define RDE_OPC_MSB         15
`define RDE_OPC_LSB         10
`define RDE_DEST_BIT        9
`define RDE_BANK_BIT        8
`define RDE_IDX_LIMIT       8'h5F
`define RDE_ACC_SPLIT       8'h60
`define RDE_ACC_HI_BANK     4'hF
`define RDE_ACC_LO_BANK     4'h0
`define RDE_FLAG_C          0
`define RDE_FLAG_DC         1
`define RDE_FLAG_Z          2
`define RDE_FLAG_OV         3
`define RDE_FLAG_N          4
`endif

// File: rde_pkg.sv
// Purpose: types for the register decrement execute block
// Assumes: four quarter phases per instruction cycle
// Notes:   flags travel as one packed struct
package rde_pkg;
   typedef enum logic [1:0]
   {
      RDE_PH_ONE   = 2'b00,
      RDE_PH_TWO   = 2'b01,
      RDE_PH_THREE = 2'b10,
      RDE_PH_FOUR  = 2'b11
   } rde_phase_t;
   typedef struct packed
   {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } rde_flags_t;
endpackage

// File: rde_core.sv
// Purpose: executes the decrement-memory instruction over four quarter phases
// Assumes: data memory answers a read in the same quarter (combinational rdata)
// Notes:   flags write out as a struct; other opcodes pass as no operation
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "rde_params.svh"
//
// Function
// RL1 - with destination bit 0 the decremented byte goes to the accumulator and memory is untouched.
// RL2 - with destination bit 1 the decremented byte is written back to the address it came from.
// RL3 - with bank-access bit 0 the operand lies in the shared access bank, bank select ignored.
// RL4 - with bank-access bit 1 the bank select register picks the general purpose bank.
// RL5 - extended set on, bank-access bit 0 and address at most 5Fh use indexed literal offset.
// RL6 - after the decrement carry, digit carry, negative, overflow and zero all follow the result.
// RL7 - zero is set when the result is zero and cleared otherwise.
// RL8 - opcode 000001 d a f is decoded in phase one, read in two, computed in three, written in four.
module rde_core
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic [15:0]       instr,
   input  wire logic              instr_valid,
   input  wire logic              ext_set_en,
   input  wire logic [3:0]        bank_select_reg,
   input  wire logic [11:0]       index_base,
   input  wire logic [7:0]        mem_rdata,
   output logic [11:0]            mem_addr,
   output logic                   mem_rd,
   output logic [7:0]             mem_wdata,
   output logic                   mem_wr,
   output logic [7:0]             acc_out,
   output logic                   acc_wr,
   output rde_pkg::rde_flags_t    flags,
   output logic                   flags_wr,
   output rde_pkg::rde_phase_t    phase,
   output logic                   busy
);
   import rde_pkg::*;

   rde_phase_t  phase_r;
   logic        hit_r;
   logic        dest_r;
   logic [7:0]  opnd_r;
   logic [7:0]  res_nxt;
   rde_flags_t  flg_nxt;
   logic [11:0] addr_r;
   logic [11:0] addr_nxt;
   logic [7:0]  foff;
   logic        dec_hit;

   assign foff = instr[7:0];
   assign dec_hit = instr_valid &&
                    (instr[`RDE_OPC_MSB:`RDE_OPC_LSB] == `RDE_OPC_DECR); // RL8

   always_comb
   begin
      if (instr[`RDE_BANK_BIT])
         addr_nxt = {bank_select_reg, foff}; // RL4
      else if (ext_set_en && (foff <= `RDE_IDX_LIMIT))
         addr_nxt = index_base + {4'h0, foff}; // RL5
      else if (foff < `RDE_ACC_SPLIT)
         addr_nxt = {`RDE_ACC_LO_BANK, foff}; // RL3
      else
         addr_nxt = {`RDE_ACC_HI_BANK, foff}; // RL3
   end

   // quarter phase sequencer; free running like the core clock split
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         phase_r <= RDE_PH_ONE;
      else
      begin
         case (phase_r)
            RDE_PH_ONE:   phase_r <= RDE_PH_TWO;
            RDE_PH_TWO:   phase_r <= RDE_PH_THREE;
            RDE_PH_THREE: phase_r <= RDE_PH_FOUR;
            RDE_PH_FOUR:  phase_r <= RDE_PH_ONE;
            default:      phase_r <= RDE_PH_ONE;
         endcase
      end
   end

   // decode in phase one
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         hit_r  <= 1'b0;
         dest_r <= 1'b0;
         addr_r <= 12'h000;
      end
      else if (phase_r == RDE_PH_ONE)
      begin
         hit_r  <= dec_hit; // RL8
         dest_r <= instr[`RDE_DEST_BIT];
         addr_r <= addr_nxt;
      end
   end

   // read in phase two
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         opnd_r <= 8'h00;
      else if (phase_r == RDE_PH_TWO && hit_r)
         opnd_r <= mem_rdata; // RL8
   end

   // compute in phase three; result and flags land on the outputs at the
   // edge that opens phase four, so no intermediate register may sit between
   assign res_nxt = opnd_r - 8'h01;

   always_comb
   begin
      // borrow-style carry: set when no borrow, i.e. operand nonzero
      flg_nxt.c  = (opnd_r != 8'h00); // RL6
      flg_nxt.dc = (opnd_r[3:0] != 4'h0); // RL6
      flg_nxt.n  = res_nxt[7]; // RL6
      flg_nxt.ov = (opnd_r == 8'h80); // RL6
      flg_nxt.z  = (res_nxt == 8'h00); // RL7
   end

   // outputs registered; write strobes fire during phase four
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         mem_addr  <= 12'h000;
         mem_rd    <= 1'b0;
         mem_wdata <= 8'h00;
         mem_wr    <= 1'b0;
         acc_out   <= 8'h00;
         acc_wr    <= 1'b0;
         flags     <= '0;
         flags_wr  <= 1'b0;
         busy      <= 1'b0;
      end
      else
      begin
         mem_addr  <= (phase_r == RDE_PH_ONE) ? addr_nxt : addr_r;
         mem_rd    <= (phase_r == RDE_PH_ONE) && dec_hit; // RL8
         mem_wdata <= (phase_r == RDE_PH_THREE && hit_r && dest_r) ? res_nxt : mem_wdata; // RL2
         mem_wr    <= (phase_r == RDE_PH_THREE) && hit_r && dest_r; // RL2
         acc_out   <= (phase_r == RDE_PH_THREE && hit_r && !dest_r) ? res_nxt : acc_out; // RL1
         acc_wr    <= (phase_r == RDE_PH_THREE) && hit_r && !dest_r; // RL1
         flags     <= (phase_r == RDE_PH_THREE && hit_r) ? flg_nxt : flags; // RL6
         flags_wr  <= (phase_r == RDE_PH_THREE) && hit_r; // RL6
         // hit_r still holds the previous word during phase one, so decode directly
         busy      <= (phase_r == RDE_PH_ONE) ? dec_hit :
                      (hit_r && (phase_r != RDE_PH_FOUR));
      end
   end

   assign phase = phase_r;
endmodule // rde_core

// File: rde_core_sva.sv
// Purpose: port assertions for rde_core
// Assumes: one clock, async low reset
// Notes:   operand word and byte captured by helper registers
`timescale 1ns/100ps
module rde_core_sva
(
   input logic mclk, resetn, instr_valid, ext_set_en, mem_rd, mem_wr, acc_wr, flags_wr,
   input logic [15:0] instr,
   input logic [3:0] bank_select_reg,
   input logic [11:0] index_base, mem_addr,
   input logic [7:0] mem_rdata, mem_wdata, acc_out,
   input rde_pkg::rde_flags_t flags,
   input rde_pkg::rde_phase_t phase
);
   import rde_pkg::*;
   logic [7:0] f_r, op_r;
   logic a_r;
   always_ff @(posedge mclk) if (phase == RDE_PH_ONE) {a_r, f_r} <= instr[8:0];
   always_ff @(posedge mclk) if (mem_rd) op_r <= mem_rdata;
   wire [7:0] res = op_r - 8'h01;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence s_take; phase == RDE_PH_ONE && instr_valid && instr[15:10] == 6'h01; endsequence
   property p_seq; s_take |=> mem_rd ##2 flags_wr; endproperty
   a_seq: assert property (p_seq) else $error("strobes off phase");
   property p_acc; s_take ##0 !instr[9] |-> ##3 acc_wr && !mem_wr && acc_out == res; endproperty
   a_acc: assert property (p_acc) else $error("accumulator write");
   property p_mem; s_take ##0 instr[9] |-> ##3 mem_wr && !acc_wr && mem_wdata == res; endproperty
   a_mem: assert property (p_mem) else $error("memory write");
   property p_shr; mem_rd && !a_r && !($past(ext_set_en) && f_r < 8'h60) |->
      mem_addr == {((f_r < 8'h60) ? 4'h0 : 4'hF), f_r}; endproperty
   a_shr: assert property (p_shr) else $error("shared bank address");
   property p_bank; mem_rd && a_r |-> mem_addr == {$past(bank_select_reg), f_r}; endproperty
   a_bank: assert property (p_bank) else $error("banked address");
   property p_idx; mem_rd && !a_r && $past(ext_set_en) && f_r < 8'h60 |->
      mem_addr == $past(index_base) + f_r; endproperty
   a_idx: assert property (p_idx) else $error("indexed address");
   property p_flg; flags_wr |-> flags == {res[7], op_r == 8'h80, !res, |op_r[3:0], |op_r};
   endproperty
   a_flg: assert property (p_flg) else $error("flag values");
   property p_z; flags_wr |-> flags.z == (op_r == 8'h01); endproperty
   a_z: assert property (p_z) else $error("zero flag");
endmodule // rde_core_sva

// File: rde_core_tb.sv
// Purpose: self-checking bench for rde_core
// Assumes: 50 MHz mclk, bench holds the operand byte
// Notes:   index base tied, so one base value is seen
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD %0t mismatch", $time); end end
module rde_core_tb;
   import rde_pkg::*;
   // row: word, ext, bank, operand, address, result, flags, {mem_wr, acc_wr}
   logic [63:0] rows [5] = '{64'h2460_0_3_01_000_00_00_0, 64'h0460_1_5_01_F60_00_07_1,
      64'h065F_1_3_80_25F_7F_09_2, 64'h045F_0_3_10_05F_0F_01_1, 64'h0712_0_3_00_312_FF_10_2};
   logic mclk = 1'h0, resetn = 1'h0, instr_valid = 1'h0, ext_set_en = 1'h0;
   logic mem_rd, mem_wr, acc_wr, flags_wr, busy;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bank_select_reg = 4'h0;
   logic [7:0] mem_rdata = 8'h00, mem_wdata, acc_out;
   logic [11:0] mem_addr;
   rde_flags_t flags;
   rde_phase_t phase;
   int bad_count = 0, n_checks = 0, k;
   rde_core i_dut (.mclk, .resetn, .instr, .instr_valid, .ext_set_en, .bank_select_reg,
      .index_base(12'h200), .mem_rdata, .mem_addr, .mem_rd, .mem_wdata, .mem_wr, .acc_out,
      .acc_wr, .flags, .flags_wr, .phase, .busy);
   initial forever #10 mclk = ~mclk;
   task automatic run(input logic [63:0] r);
      int n;
      for (n = 0; phase !== RDE_PH_FOUR && n < 8; n++) @(negedge mclk);
      if (n == 8) end_of_test(1);
      @(posedge mclk);
      {instr, ext_set_en, bank_select_reg, mem_rdata} <= {r[63:48], r[44], r[43:32]};
      repeat (2) @(negedge mclk);
      `CHK({mem_rd, busy}, {2{|r[1:0]}})
      if (|r[1:0]) `CHK(mem_addr, r[31:20])
      repeat (2) @(negedge mclk);
      `CHK({mem_wr, acc_wr, flags_wr}, {r[1:0], |r[1:0]})
      if (|r[1:0]) `CHK({flags, mem_wr ? mem_wdata : acc_out}, {r[8:4], r[19:12]})
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      resetn <= 1'h1;
      instr_valid <= 1'h1;
      for (k = 0; k < 5; k++) run(rows[k]);
      $display("row tests done");
      // last word is still presented, so it is taken again; cut it in phase two
      repeat (2) @(posedge mclk);
      resetn <= 1'h0;
      #1;
      `CHK({mem_rd, mem_wr, acc_wr, flags_wr, busy, phase, flags, acc_out}, 20'h00000)
      repeat (2) @(posedge mclk);
      resetn <= 1'h1;
      run(rows[2]);
      $display("reset test done");
      end_of_test(0);
   end
   task end_of_test(input int late);
      bad_count += late;
      $display("checks %0d bad %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
endmodule // rde_core_tb
bind rde_core rde_core_sva i_sva (.mclk, .resetn, .instr, .instr_valid, .ext_set_en,
   .bank_select_reg, .index_base, .mem_rdata, .mem_addr, .mem_rd, .mem_wdata, .mem_wr,
   .acc_out, .acc_wr, .flags, .flags_wr, .phase);
